// ===== verilog/eirq_top.sv
// The Avalon-MM interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`include "eirq_params.svh"

// Behaviour
// - pin activity raises interrupts even while the pin is driven as output
// - enabled low-level mode keeps requesting while the pin stays low, except while the deep-sleep wake sequence runs
// - edge detection only runs while the I/O clock runs
// - low-level detection works without the I/O clock
// - deep-sleep wake needs two low samples on watchdog ticks
// - level gone before start-up end: wake anyway, no interrupt
// - pin 1 sense: 00 low, 01 change, 10 fall, 11 rise
// - pin 0 sense uses the same encoding as pin 1
// - pin sampled before edge detect; pulses over one clock caught
// - request needs enable bit and global enable; bit 7 pin 1, bit 6 pin 0
// - each pin has its own vector request
// - pin event sets its pending flag; bit 7 pin 1, bit 6 pin 0
// - flag, enable and global enable together request the vector
// - flag clears on vector entry or written one; zero leaves it
// - flag reads cleared while pin is in low-level mode

module eirq_top #(
    parameter int STARTUP_CYCLES = `EIRQ_STARTUP_CYC
)(
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        ext_irq0_line,
    input  wire logic        ext_irq1_line,
    input  wire logic        global_irq_en,
    input  wire logic [1:0]  vec_ack,
    input  wire logic        io_clk_run,
    input  wire logic        sleep_deep,
    input  wire logic        wdt_tick,
    output logic      [1:0]  irq_vec_req,
    output logic             irq,
    output logic             wake_req
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    eirq_pkg::eirq_bus_t  bus;
    eirq_pkg::eirq_pins_t pins;
    eirq_pkg::eirq_pins_t next_pins;
    logic [3:0]           sense_ctl;
    logic [3:0]           next_sense_ctl;
    logic [1:0]           en;
    logic [1:0]           next_en;
    logic [1:0]           flag;
    logic [1:0]           next_flag;
    logic [1:0]           ev;
    logic [1:0]           w1c;
    logic [1:0]           lvl_act;
    logic [1:0]           next_irq_vec_req;
    logic                 next_irq;
    logic [31:0]          next_readdata;
    logic                 next_waitrequest;
    logic                 wr_fire;
    logic                 lvl_gate;
    logic                 wake_out;
    logic                 lvl_low_any;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic edge_event(
        input logic [1:0] mode,
        input logic       prev,
        input logic       cur
    );
        logic hit;
        hit = 1'b0;
        case (eirq_pkg::eirq_sense_t'(mode))
            eirq_pkg::EIRQ_SENSE_ANY:  hit = prev ^ cur;
            eirq_pkg::EIRQ_SENSE_FALL: hit = prev & ~cur;
            eirq_pkg::EIRQ_SENSE_RISE: hit = ~prev & cur;
            default:                   hit = 1'b0;
        endcase
        return hit;
    endfunction

    function automatic logic is_level(input logic [1:0] mode);
        return eirq_pkg::eirq_sense_t'(mode) == eirq_pkg::EIRQ_SENSE_LOW;
    endfunction

    // ----------------------------------------------------------------
    // bus capture
    // ----------------------------------------------------------------
    always_comb
    begin
        bus.rd    = avs_read;
        bus.wr    = avs_write;
        bus.addr  = avs_address;
        bus.wdata = avs_writedata[7:0];
        bus.be0   = avs_byteenable[0];
    end

    // writes take effect only on the edge where waitrequest is low
    assign wr_fire = bus.wr && !avs_waitrequest && bus.be0;

    // ----------------------------------------------------------------
    // pin sampling
    // ----------------------------------------------------------------
    // pad level is read regardless of port direction, so software
    // driving the pin as an output still raises the interrupt
    always_comb
    begin
        next_pins     = pins;
        // level copy runs on every edge, independent of the I/O clock
        next_pins.lvl = {ext_irq1_line, ext_irq0_line};
        if (io_clk_run)
        begin
            // a frozen I/O clock freezes the edge sampler too
            next_pins.cur  = {ext_irq1_line, ext_irq0_line};
            next_pins.prev = pins.cur;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
            pins <= '{cur: 2'b11, prev: 2'b11, lvl: 2'b11};
        else
            pins <= next_pins;
    end

    // ----------------------------------------------------------------
    // pending flags
    // ----------------------------------------------------------------
    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            ev[i]      = io_clk_run
                         && edge_event(sense_ctl[2*i +: 2], pins.prev[i], pins.cur[i]);
            w1c[i]     = wr_fire && bus.addr == `EIRQ_OFF_FLAGS
                         && bus.wdata[`EIRQ_FLAG_BIT_BASE + i];
            lvl_act[i] = is_level(sense_ctl[2*i +: 2]) && !pins.lvl[i];
        end
    end

    always_comb
    begin
        next_flag = flag;
        for (int i = 0; i < 2; i++)
        begin
            if (is_level(sense_ctl[2*i +: 2]))
                next_flag[i] = 1'b0;
            else if (ev[i])
                next_flag[i] = 1'b1;
            else if (vec_ack[i] || w1c[i])
                next_flag[i] = 1'b0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
            flag <= `EIRQ_FLAGS_RST;
        else
            flag <= next_flag;
    end

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    always_comb
    begin
        next_sense_ctl = sense_ctl;
        next_en        = en;
        if (wr_fire && bus.addr == `EIRQ_OFF_SENSE)
            next_sense_ctl = bus.wdata[3:0];
        else if (wr_fire && bus.addr == `EIRQ_OFF_ENABLE)
            next_en = bus.wdata[`EIRQ_EN_BIT_BASE +: 2];
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            sense_ctl <= `EIRQ_SENSE_RST;
            en        <= `EIRQ_ENABLE_RST;
        end
        else
        begin
            sense_ctl <= next_sense_ctl;
            en        <= next_en;
        end
    end

    // ----------------------------------------------------------------
    // wake filter
    // ----------------------------------------------------------------
    assign lvl_low_any = |(lvl_act & en);

    eirq_wake_filter #(
        .STARTUP_CYCLES (STARTUP_CYCLES)
    ) i_eirq_wake_filter (
        .sys_clk    (sys_clk),
        .nrst       (nrst),
        .sleep_deep (sleep_deep),
        .wdt_tick   (wdt_tick),
        .lvl_low    (lvl_low_any),
        .wake_req   (wake_out),
        .lvl_gate   (lvl_gate)
    );

    // ----------------------------------------------------------------
    // vector requests
    // ----------------------------------------------------------------
    // level requests wait for the wake sequence to finish, so a level
    // that vanished during start-up never reaches the core
    always_comb
    begin
        for (int i = 0; i < 2; i++)
            next_irq_vec_req[i] = global_irq_en && en[i]
                                  && (flag[i] || (lvl_act[i] && lvl_gate));
        next_irq = |next_irq_vec_req;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            irq_vec_req <= 2'b00;
            irq         <= 1'b0;
            wake_req    <= 1'b0;
        end
        else
        begin
            irq_vec_req <= next_irq_vec_req;
            irq         <= next_irq;
            wake_req    <= wake_out;
        end
    end

    // ----------------------------------------------------------------
    // bus slave
    // ----------------------------------------------------------------
    // one wait state: read data is built while waitrequest is high
    always_comb
    begin
        next_waitrequest = 1'b1;
        next_readdata    = avs_readdata;
        if ((bus.rd || bus.wr) && avs_waitrequest)
        begin
            next_waitrequest = 1'b0;
            next_readdata    = `EIRQ_RDATA_RST;
            if (bus.rd)
            begin
                if (bus.addr == `EIRQ_OFF_SENSE)
                    next_readdata[3:0] = sense_ctl;
                else if (bus.addr == `EIRQ_OFF_ENABLE)
                    next_readdata[`EIRQ_EN_BIT_BASE +: 2] = en;
                else if (bus.addr == `EIRQ_OFF_FLAGS)
                    next_readdata[`EIRQ_FLAG_BIT_BASE +: 2] = flag;
                else if (bus.addr == `EIRQ_OFF_STATE)
                begin
                    next_readdata[1:0]                  = pins.lvl;
                    next_readdata[`EIRQ_STATE_WAKE_BIT] = wake_out;
                    next_readdata[`EIRQ_STATE_GATE_BIT] = lvl_gate;
                end
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= `EIRQ_RDATA_RST;
        end
        else
        begin
            avs_waitrequest <= next_waitrequest;
            avs_readdata    <= next_readdata;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    sequence s_level_held0;
        is_level(sense_ctl[1:0]) && en[0] && global_irq_en && lvl_gate && !ext_irq0_line;
    endsequence

    AST_LEVEL_KEEPS_REQ: assert property (
        s_level_held0 [*2] |=> irq_vec_req[0])
        else $error("held low level lost its request");

    AST_EDGE_NEEDS_CLOCK: assert property (
        (!io_clk_run && !flag[0] && !is_level(sense_ctl[1:0])) |=> !flag[0])
        else $error("edge flag set with stopped clock");

    AST_PIN1_RISE: assert property (
        (sense_ctl[3:2] == 2'b11 && io_clk_run && !pins.prev[1] && pins.cur[1]) |=> flag[1])
        else $error("rising edge on pin 1 missed");

    AST_PIN0_FALL: assert property (
        (sense_ctl[1:0] == 2'b10 && io_clk_run && pins.prev[0] && !pins.cur[0]) |=> flag[0])
        else $error("falling edge on pin 0 missed");

    AST_PULSE_CAUGHT: assert property (
        (sense_ctl[1:0] == 2'b01 && io_clk_run && !ext_irq0_line ##1
         io_clk_run && ext_irq0_line ##1 io_clk_run) |=> flag[0])
        else $error("two-cycle pulse not flagged");

    AST_NEEDS_GLOBAL: assert property (
        !global_irq_en |=> irq_vec_req == 2'b00 && !irq)
        else $error("request without global enable");

    AST_FLAG_REQUESTS: assert property (
        (flag[1] && en[1] && global_irq_en) |=> irq_vec_req[1] ##0 irq)
        else $error("pending flag did not request vector");

    AST_ACK_CLEARS: assert property (
        (vec_ack[1] && !ev[1]) |=> !flag[1])
        else $error("acknowledge did not clear flag");

    AST_WRITE_ZERO_KEEPS: assert property (
        (wr_fire && bus.addr == `EIRQ_OFF_FLAGS && !bus.wdata[`EIRQ_FLAG_BIT_BASE + 1]
         && flag[1] && !vec_ack[1] && !is_level(sense_ctl[3:2])) |=> flag[1])
        else $error("writing zero cleared a flag");

    AST_LEVEL_FLAG_ZERO: assert property (
        is_level(sense_ctl[1:0]) |=> !flag[0] || !is_level($past(sense_ctl[1:0])))
        else $error("flag set in low-level mode");

    AST_BUS_ONE_WAIT: assert property (
        ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not after one wait state");

endmodule

// ===== inc/eirq_params.svh
`ifndef EIRQ_PARAMS_SVH
`define EIRQ_PARAMS_SVH

// ----------------------------------------------------------------
// register word offsets (byte addresses)
// ----------------------------------------------------------------
`define EIRQ_OFF_SENSE      4'h0
`define EIRQ_OFF_ENABLE     4'h4
`define EIRQ_OFF_FLAGS      4'h8
`define EIRQ_OFF_STATE      4'hC

// ----------------------------------------------------------------
// field positions (pin i sits at BASE + i, or 2*i for sense)
// ----------------------------------------------------------------
`define EIRQ_EN_BIT_BASE    6
`define EIRQ_FLAG_BIT_BASE  6
`define EIRQ_STATE_WAKE_BIT 2
`define EIRQ_STATE_GATE_BIT 3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define EIRQ_SENSE_RST      4'h0
`define EIRQ_ENABLE_RST     2'h0
`define EIRQ_FLAGS_RST      2'h0
`define EIRQ_RDATA_RST      32'h0000_0000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define EIRQ_CLK_PERIOD_NS  50
`define EIRQ_STARTUP_NS     65000
`define EIRQ_STARTUP_CYC    ((`EIRQ_STARTUP_NS + `EIRQ_CLK_PERIOD_NS - 1) / `EIRQ_CLK_PERIOD_NS)

`endif

// ===== inc/eirq_pkg.sv
package eirq_pkg;

    typedef enum logic [1:0]
    {
        EIRQ_SENSE_LOW  = 2'b00,
        EIRQ_SENSE_ANY  = 2'b01,
        EIRQ_SENSE_FALL = 2'b10,
        EIRQ_SENSE_RISE = 2'b11
    } eirq_sense_t;

    typedef enum logic [1:0]
    {
        EIRQ_WK_IDLE   = 2'b00,
        EIRQ_WK_SAMPLE = 2'b01,
        EIRQ_WK_START  = 2'b10
    } eirq_wake_t;

    typedef struct packed
    {
        logic       rd;
        logic       wr;
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       be0;
    } eirq_bus_t;

    typedef struct packed
    {
        logic [1:0] cur;
        logic [1:0] prev;
        logic [1:0] lvl;
    } eirq_pins_t;

endpackage

// ===== verilog/eirq_wake_filter.sv
`timescale 1ns/1ps
`include "eirq_params.svh"

module eirq_wake_filter #(
    parameter int STARTUP_CYCLES = `EIRQ_STARTUP_CYC
)(
    input  wire logic sys_clk,
    input  wire logic nrst,
    input  wire logic sleep_deep,
    input  wire logic wdt_tick,
    input  wire logic lvl_low,
    output logic      wake_req,
    output logic      lvl_gate
);

    eirq_pkg::eirq_wake_t state;
    eirq_pkg::eirq_wake_t next_state;
    logic [15:0]          cnt;
    logic [15:0]          next_cnt;

    // ----------------------------------------------------------------
    // two watchdog-tick samples, then the start-up wait
    // ----------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        next_cnt   = cnt;
        case (state)
            eirq_pkg::EIRQ_WK_IDLE:
            begin
                if (sleep_deep && wdt_tick && lvl_low)
                    next_state = eirq_pkg::EIRQ_WK_SAMPLE;
            end
            eirq_pkg::EIRQ_WK_SAMPLE:
            begin
                if (!sleep_deep)
                    next_state = eirq_pkg::EIRQ_WK_IDLE;
                else if (wdt_tick)
                begin
                    // noise that went away between ticks does not wake
                    if (lvl_low)
                    begin
                        next_state = eirq_pkg::EIRQ_WK_START;
                        next_cnt   = 16'(STARTUP_CYCLES - 1);
                    end
                    else
                        next_state = eirq_pkg::EIRQ_WK_IDLE;
                end
            end
            eirq_pkg::EIRQ_WK_START:
            begin
                // wake goes ahead even if the level drops meanwhile
                if (cnt == 16'h0000)
                    next_state = eirq_pkg::EIRQ_WK_IDLE;
                else
                    next_cnt = cnt - 16'h0001;
            end
            default:
                next_state = eirq_pkg::EIRQ_WK_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            state    <= eirq_pkg::EIRQ_WK_IDLE;
            cnt      <= 16'h0000;
            wake_req <= 1'b0;
            lvl_gate <= 1'b1;
        end
        else
        begin
            state    <= next_state;
            cnt      <= next_cnt;
            wake_req <= (next_state == eirq_pkg::EIRQ_WK_START);
            lvl_gate <= (next_state == eirq_pkg::EIRQ_WK_IDLE);
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    AST_WAKE_TWO_SAMPLES: assert property (
        $rose(wake_req) |-> $past(state) == eirq_pkg::EIRQ_WK_SAMPLE && $past(lvl_low)
            && $past(wdt_tick))
        else $error("wake without two low samples");

    AST_WAKE_HOLDS: assert property (
        (state == eirq_pkg::EIRQ_WK_START && cnt != 16'h0000) |=> wake_req && !lvl_gate)
        else $error("wake dropped before start-up end");

endmodule

// ===== tb/eirq_pin_src.sv
`timescale 1ns/1ps

module eirq_pin_src (
    input  wire logic sys_clk,
    output logic      ext_irq0_line,
    output logic      ext_irq1_line
);
    logic [1:0] lvl;

    initial lvl = 2'h3;
    assign ext_irq0_line = lvl[0];
    assign ext_irq1_line = lvl[1];

    // a level stays put until the next call, so the wake hold is the caller's choice
    task automatic drive(input int pin, input logic v);
        @(posedge sys_clk);
        lvl[pin] <= v;
    endtask

    // width in whole cycles; one cycle is below the guaranteed width
    task automatic pulse(input int pin, input int cyc);
        drive(pin, ~lvl[pin]);
        repeat (cyc) @(posedge sys_clk);
        lvl[pin] <= ~lvl[pin];
    endtask
endmodule

// ===== tb/eirq_top_test.sv
`timescale 1ns/1ps
`include "eirq_params.svh"

module eirq_top_test;
    localparam int SU = 8;
    logic        sys_clk = 1'b0;
    logic        nrst = 1'b0;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        ext_irq0_line;
    logic        ext_irq1_line;
    logic        global_irq_en = 1'b0;
    logic [1:0]  vec_ack = 2'h0;
    logic        io_clk_run = 1'b1;
    logic        sleep_deep = 1'b0;
    logic        wdt_tick = 1'b0;
    logic [1:0]  irq_vec_req;
    logic        irq;
    logic        wake_req;
    int          bad_count = 0;
    int          checks = 0;
    int          cycles = 0;

    always #25 sys_clk = ~sys_clk;

    eirq_top #(.STARTUP_CYCLES(SU)) i_eirq_top (
        .sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .ext_irq0_line(ext_irq0_line),
        .ext_irq1_line(ext_irq1_line), .global_irq_en(global_irq_en), .vec_ack(vec_ack),
        .io_clk_run(io_clk_run), .sleep_deep(sleep_deep), .wdt_tick(wdt_tick),
        .irq_vec_req(irq_vec_req), .irq(irq), .wake_req(wake_req)
    );

    eirq_pin_src i_pin_src (
        .sys_clk(sys_clk), .ext_irq0_line(ext_irq0_line), .ext_irq1_line(ext_irq1_line)
    );

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic wrap_up;
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // request held until the edge that samples waitrequest low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
                       input logic [3:0] be, output logic [31:0] q);
        @(posedge sys_clk);
        avs_read       <= !wr;
        avs_write      <= wr;
        avs_address    <= a;
        avs_writedata  <= {24'h0, d};
        avs_byteenable <= be;
        // if waitrequest never drops, only the bench timeout ends this wait
        do
            @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, 4'hF, q);
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 8'h0, 4'hF, q);
        chk(q, exp);
    endtask

    task automatic tick;
        @(posedge sys_clk);
        wdt_tick <= 1'b1;
        @(posedge sys_clk);
        wdt_tick <= 1'b0;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_regs;
        logic [31:0] q;
        chk({30'h0, irq, wake_req}, 32'h0);
        rd_chk(`EIRQ_OFF_SENSE, 32'h0);
        rd_chk(`EIRQ_OFF_FLAGS, 32'h0);
        rd_chk(`EIRQ_OFF_STATE, 32'h0B);
        wr(`EIRQ_OFF_SENSE, 8'h0E);
        bus(1'b1, `EIRQ_OFF_SENSE, 8'h00, 4'h0, q);
        rd_chk(`EIRQ_OFF_SENSE, 32'h0E);
        wr(`EIRQ_OFF_ENABLE, 8'hC0);
        rd_chk(`EIRQ_OFF_ENABLE, 32'hC0);
        rd_chk(4'h2, 32'h0);
        wr(`EIRQ_OFF_ENABLE, 8'h00);
    endtask

    // every edge code on both pins; low-level pin's flag stays clear
    task automatic t_edges;
        logic [7:0] s;
        logic [7:0] b;
        for (int p = 0; p < 2; p++)
            for (int m = 1; m < 4; m++)
            begin
                s = 8'(m) << (2 * p);
                b = 8'h40 << p;
                wr(`EIRQ_OFF_SENSE, s);
                wr(`EIRQ_OFF_FLAGS, 8'hC0);
                i_pin_src.drive(p, 1'b0);
                cyc(3);
                rd_chk(`EIRQ_OFF_FLAGS, (m == 1 || m == 2) ? b : 8'h0);
                wr(`EIRQ_OFF_FLAGS, 8'hC0);
                i_pin_src.drive(p, 1'b1);
                cyc(3);
                rd_chk(`EIRQ_OFF_FLAGS, (m == 1 || m == 3) ? b : 8'h0);
                wr(`EIRQ_OFF_FLAGS, 8'h00);
                rd_chk(`EIRQ_OFF_FLAGS, (m == 1 || m == 3) ? b : 8'h0);
                wr(`EIRQ_OFF_FLAGS, b);
                rd_chk(`EIRQ_OFF_FLAGS, 32'h0);
            end
    endtask

    // frozen sampling must miss a pulse that a running clock catches
    task automatic t_pulse;
        wr(`EIRQ_OFF_SENSE, 8'h03);
        io_clk_run <= 1'b0;
        i_pin_src.pulse(0, 2);
        cyc(3);
        io_clk_run <= 1'b1;
        cyc(3);
        rd_chk(`EIRQ_OFF_FLAGS, 32'h0);
        i_pin_src.pulse(0, 2);
        cyc(3);
        rd_chk(`EIRQ_OFF_FLAGS, 32'h40);
        wr(`EIRQ_OFF_FLAGS, 8'h40);
    endtask

    task automatic t_vec;
        wr(`EIRQ_OFF_SENSE, 8'h08);
        i_pin_src.drive(1, 1'b0);
        cyc(4);
        chk({29'h0, irq, irq_vec_req}, 32'h0);
        wr(`EIRQ_OFF_ENABLE, 8'h80);
        cyc(3);
        chk({29'h0, irq, irq_vec_req}, 32'h0);
        global_irq_en <= 1'b1;
        cyc(3);
        chk({29'h0, irq, irq_vec_req}, 32'h6);
        vec_ack <= 2'h1;
        cyc(1);
        vec_ack <= 2'h0;
        cyc(3);
        chk({29'h0, irq, irq_vec_req}, 32'h6);
        vec_ack <= 2'h2;
        cyc(1);
        vec_ack <= 2'h0;
        cyc(3);
        chk({29'h0, irq, irq_vec_req}, 32'h0);
        rd_chk(`EIRQ_OFF_FLAGS, 32'h0);
        i_pin_src.drive(1, 1'b1);
        wr(`EIRQ_OFF_ENABLE, 8'h00);
    endtask

    task automatic t_level;
        wr(`EIRQ_OFF_SENSE, 8'h00);
        wr(`EIRQ_OFF_ENABLE, 8'h40);
        i_pin_src.drive(0, 1'b0);
        cyc(3);
        chk({30'h0, irq_vec_req}, 32'h1);
        io_clk_run <= 1'b0;
        cyc(10);
        chk({30'h0, irq_vec_req}, 32'h1);
        rd_chk(`EIRQ_OFF_FLAGS, 32'h0);
        i_pin_src.drive(0, 1'b1);
        cyc(3);
        chk({30'h0, irq_vec_req}, 32'h0);
        io_clk_run <= 1'b1;
    endtask

    // two ticks with the level low start the wake; hold decides the request
    task automatic wake_run(input logic hold);
        int n = 0;
        int len = 1;
        logic [1:0] seen = 2'h0;
        i_pin_src.drive(0, 1'b0);
        tick;
        cyc(3);
        tick;
        while (wake_req !== 1'b1 && n < 20)
        begin
            @(posedge sys_clk);
            n++;
        end
        if (!hold)
            i_pin_src.drive(0, 1'b1);
        else
            cyc(1);
        while (wake_req === 1'b1 && len < 50)
        begin
            len++;
            seen = seen | irq_vec_req;
            @(posedge sys_clk);
        end
        cyc(3);
        chk(len, SU);
        chk({30'h0, seen}, 32'h0);
        chk({30'h0, irq_vec_req}, hold ? 32'h1 : 32'h0);
        i_pin_src.drive(0, 1'b1);
        cyc(3);
    endtask

    task automatic t_wake;
        sleep_deep <= 1'b1;
        wr(`EIRQ_OFF_ENABLE, 8'h40);
        i_pin_src.drive(0, 1'b0);
        tick;
        i_pin_src.drive(0, 1'b1);
        cyc(3);
        tick;
        cyc(4);
        chk({31'h0, wake_req}, 32'h0);
        wake_run(1'b0);
        wake_run(1'b1);
        sleep_deep <= 1'b0;
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            wrap_up;
        end
    end

    initial
    begin
        cyc(16);
        nrst <= 1'b1;
        cyc(1);
        t_regs;
        t_edges;
        t_pulse;
        t_vec;
        t_level;
        t_wake;
        wrap_up;
    end
endmodule
